/* core/pxc_crossbar.sv */
/*
  Priority crossbar: places enabled peripheral signals on port pins and
  drives the pad controls (output value, enable, weak pullup).
  Assumes peripherals on the same clock and pads sampled from outside.
*/
// Added by the designer: the strobed register port.
// Contract
// - Enabled peripherals placed by priority onto lowest free, unskipped pin.
// - UART transmit always on P0.4, receive always on P0.5.
// - A pin already given away is passed over for later peripherals.
// - Skipped pins count as occupied and are never routed, except the fixed UART pins P0.4 and P0.5.
// - SMBus claims two consecutive free pins; UART claims both pins.
// - Pins left after routing act as ordinary port I/O.
// - Special-function signals are never placed by the crossbar.
// - SPI slave select routed only in 4-wire mode.
// - P2.1-P2.4 only in large package; small package keeps P2.0 as port I/O but out of the crossbar.
// - Input mode bit 1 is digital, 0 analog; reset is digital.
// - Analog pins have pullup, driver and receiver disabled.
// - Output mode bit picks push-pull or open-drain, even for peripherals.
// - SMBus pins always drive open-drain.
// - Open-drain pins get pullup unless disabled; off while driving zero.
// - Crossbar disabled keeps every driver off and ignores routing; pin values and SMBus open-drain pullups still follow it.
// - Low route bits 5,4,3 route async comparator, comparator, clock out.
// - Low route bits 2,1,0 route SMBus, SPI, UART.
// - Low route bits 7:6 read zero and ignore writes.
// - High route bit 7 disables pullups, bit 6 enables crossbar; reset zero.
// - High route bits 5,4,3 route timer 1, timer 0, counter clock.
// - Counter module field routes none, module 0, 0-1, or 0-2.
`timescale 1ns/10ps
`default_nettype none

module pxc_crossbar
#(
  parameter int LARGE_PKG = 1
)
(
  input  wire logic                      CLK_IN,
  input  wire logic                      SRST_IN,
  input  wire logic [7:0]                ADDR_IN,
  input  wire logic [7:0]                WDATA_IN,
  input  wire logic                      WR_IN,
  input  wire logic                      RD_IN,
  output logic      [7:0]                RDATA_OUT,
  input  wire logic                      SPI_FOUR_WIRE_IN,
  input  wire logic [pxc_pkg::NSLOT-1:0] PERIPH_O_IN,
  input  wire logic [pxc_pkg::NSLOT-1:0] PERIPH_OE_IN,
  output logic      [pxc_pkg::NSLOT-1:0] PERIPH_I_OUT,
  input  wire logic [pxc_pkg::NPIN-1:0]  PIN_I_IN,
  output logic      [pxc_pkg::NPIN-1:0]  PIN_O_OUT,
  output logic      [pxc_pkg::NPIN-1:0]  PIN_OE_OUT,
  output logic      [pxc_pkg::NPIN-1:0]  PIN_PU_OUT
);
  import pxc_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (LARGE_PKG != 0 && LARGE_PKG != 1)
  begin : g_bad_pkg
    $error("LARGE_PKG must be 0 or 1.");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]       route_lo_q;
  logic [7:0]       route_hi_q;
  logic [7:0]       skip_q  [NPORT];
  logic [7:0]       mdin_q  [NPORT];
  logic [7:0]       mdout_q [NPORT];
  logic [7:0]       port_q  [NPORT];
  logic [NPIN-1:0]  pin_s1_q;
  logic [NPIN-1:0]  pin_s2_q;
  logic [7:0]       rdata_d;
  logic [NPIN-1:0]  avail;
  logic [NPIN-1:0]  xbar_ok;
  logic [NPIN-1:0]  skip_vec;
  logic [NPIN-1:0]  mdin_vec;
  logic [NPIN-1:0]  mdout_vec;
  logic [NPIN-1:0]  port_vec;
  logic [NPIN-1:0]  pad_vec;
  logic [NSLOT-1:0] slot_en;
  logic [NPIN-1:0]  sel_v;
  logic [4:0]       sel_s [NPIN];
  logic [NPIN-1:0]  pin_o_d;
  logic [NPIN-1:0]  pin_oe_d;
  logic [NPIN-1:0]  pin_pu_d;
  logic [NSLOT-1:0] periph_i_d;
  logic             xbar_en;
  logic             wpud;

  assign skip_vec  = {skip_q[2][4:0], skip_q[1], skip_q[0]};
  assign mdin_vec  = {mdin_q[2][4:0], mdin_q[1], mdin_q[0]};
  assign mdout_vec = {mdout_q[2][4:0], mdout_q[1], mdout_q[0]};
  assign port_vec  = {port_q[2][4:0], port_q[1], port_q[0]};
  assign pad_vec   = pin_s2_q & mdin_vec;
  assign xbar_en   = route_hi_q[HI_XBAR];
  assign wpud      = route_hi_q[HI_WPUD];

  // ----------------------------------------------------------------
  // Package pin availability
  // ----------------------------------------------------------------
  always_comb
  begin
    avail   = '1;
    xbar_ok = '1;
    if (LARGE_PKG == 0)
    begin
      avail[NPIN-1:P20_PIN+1]   = '0;
      xbar_ok[NPIN-1:P20_PIN]   = '0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      route_lo_q <= ROUTE_RST;
      route_hi_q <= ROUTE_RST;
    end
    else if (WR_IN)
    begin
      if (ADDR_IN == ADDR_ROUTE_LO)
        route_lo_q <= WDATA_IN & ROUTE_LO_MASK;
      if (ADDR_IN == ADDR_ROUTE_HI)
        route_hi_q <= WDATA_IN & ROUTE_HI_MASK;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    for (int i = 0; i < NPORT; i++)
    begin
      if (SRST_IN)
      begin
        skip_q[i]  <= SKIP_RST;
        mdin_q[i]  <= MDIN_RST;
        mdout_q[i] <= MDOUT_RST;
        port_q[i]  <= PORT_RST;
      end
      else if (WR_IN)
      begin
        if (ADDR_IN == ADDR_SKIP_BASE + 8'(i))
          skip_q[i] <= WDATA_IN;
        if (ADDR_IN == ADDR_MDIN_BASE + 8'(i))
          mdin_q[i] <= WDATA_IN;
        if (ADDR_IN == ADDR_MDOUT_BASE + 8'(i))
          mdout_q[i] <= WDATA_IN;
        if (ADDR_IN == ADDR_PORT_BASE + 8'(i))
          port_q[i] <= WDATA_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = 8'h00;
    if (ADDR_IN == ADDR_ROUTE_LO)
      rdata_d = route_lo_q;
    if (ADDR_IN == ADDR_ROUTE_HI)
      rdata_d = route_hi_q;
    for (int i = 0; i < NPORT; i++)
    begin
      if (ADDR_IN == ADDR_SKIP_BASE + 8'(i))
        rdata_d = skip_q[i];
      if (ADDR_IN == ADDR_MDIN_BASE + 8'(i))
        rdata_d = mdin_q[i];
      if (ADDR_IN == ADDR_MDOUT_BASE + 8'(i))
        rdata_d = mdout_q[i];
      if (ADDR_IN == ADDR_PORT_BASE + 8'(i))
        rdata_d = (i == 0) ? pad_vec[7:0] :
                  (i == 1) ? pad_vec[15:8] : {3'h0, pad_vec[20:16]};
    end
    if (ADDR_IN == ADDR_SKIP_BASE + 8'h02 || ADDR_IN == ADDR_MDIN_BASE + 8'h02 ||
        ADDR_IN == ADDR_MDOUT_BASE + 8'h02 || ADDR_IN == ADDR_PORT_BASE + 8'h02)
      rdata_d = rdata_d & PORT2_MASK;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      RDATA_OUT <= 8'h00;
    else if (RD_IN)
      RDATA_OUT <= rdata_d;
    else
      RDATA_OUT <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= PIN_I_IN;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Slot enables
  // ----------------------------------------------------------------
  always_comb
  begin
    slot_en[1:0]  = {2{route_lo_q[LO_UART]}};
    slot_en[4:2]  = {3{route_lo_q[LO_SPI]}};
    // slave select only in 4-wire mode
    slot_en[SL_NSS] = route_lo_q[LO_SPI] & SPI_FOUR_WIRE_IN;
    // SMBus takes data and clock together
    slot_en[7:6]  = {2{route_lo_q[LO_SMB]}};
    slot_en[8]    = route_lo_q[LO_CMP];
    slot_en[9]    = route_lo_q[LO_CMPA];
    slot_en[10]   = route_lo_q[LO_SYSCK];
    slot_en[SL_COUNTER_MODULE0_PIN]   = route_hi_q[HI_CMOD+1 -: 2] != 2'h0;
    slot_en[SL_COUNTER_MODULE0_PIN+1] = route_hi_q[HI_CMOD+1];
    slot_en[SL_COUNTER_MODULE0_PIN+2] = route_hi_q[HI_CMOD+1 -: 2] == 2'h3;
    slot_en[14]   = route_hi_q[HI_ECI];
    slot_en[15]   = route_hi_q[HI_T0];
    slot_en[16]   = route_hi_q[HI_T1];
  end

  // ----------------------------------------------------------------
  // Priority decoder
  // ----------------------------------------------------------------
  // assignment follows current registers
  always_comb
  begin
    logic [NPIN-1:0] taken;
    logic            found;
    // skipped pins are treated as occupied
    taken = ~xbar_ok | skip_vec;
    found = 1'b0;
    sel_v = '0;
    for (int p = 0; p < NPIN; p++)
      sel_s[p] = 5'h00;
    if (slot_en[SL_URX])
    begin
      sel_v[UART_TX_PIN]  = 1'b1;
      sel_s[UART_TX_PIN]  = SL_UTX;
      sel_v[UART_RX_PIN]  = 1'b1;
      sel_s[UART_RX_PIN]  = SL_URX;
      taken[UART_TX_PIN]  = 1'b1;
      taken[UART_RX_PIN]  = 1'b1;
    end
    // priority order onto lowest free pin
    for (int s = 2; s < NSLOT; s++)
    begin
      found = 1'b0;
      if (slot_en[s])
      begin
        for (int p = 0; p < NPIN; p++)
        begin
          if (!found && !taken[p])
          begin
            sel_v[p] = 1'b1;
            sel_s[p] = 5'(s);
            taken[p] = 1'b1;
            found    = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad control per pin
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPIN; p++)
  begin : g_pin
    logic val;
    logic drv;
    logic od;
    logic smb;

    assign smb = sel_v[p] && (sel_s[p] == SL_SDA || sel_s[p] == SL_SCL);
    // unrouted pins carry the port latch
    assign val = sel_v[p] ? PERIPH_O_IN[sel_s[p]] : port_vec[p];
    assign drv = sel_v[p] ? PERIPH_OE_IN[sel_s[p]] : 1'b1;
    assign od  = ~mdout_vec[p] | smb;

    always_comb
    begin
      pin_o_d[p]  = od ? 1'b0 : val;
      pin_oe_d[p] = xbar_en & mdin_vec[p] & avail[p] & drv & (~od | ~val);
      pin_pu_d[p] = mdin_vec[p] & avail[p] & ~wpud & od &
                    ~(xbar_en & drv & ~val);
    end
  end

  // ----------------------------------------------------------------
  // Peripheral inputs
  // ----------------------------------------------------------------
  always_comb
  begin
    periph_i_d = '1;
    for (int p = 0; p < NPIN; p++)
    begin
      if (xbar_en && sel_v[p])
        periph_i_d[sel_s[p]] = pad_vec[p];
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      PIN_O_OUT    <= '0;
      PIN_OE_OUT   <= '0;
      PIN_PU_OUT   <= '0;
      PERIPH_I_OUT <= '1;
    end
    else
    begin
      PIN_O_OUT    <= pin_o_d;
      PIN_OE_OUT   <= pin_oe_d;
      PIN_PU_OUT   <= pin_pu_d;
      PERIPH_I_OUT <= periph_i_d;
    end
  end

endmodule

`default_nettype wire

/* shared/pxc_pkg.sv */
/*
  Constants shared by the priority I/O crossbar: register offsets, field
  positions, reset values, pin and peripheral slot numbering.
  Assumes an 8-bit register port and a 21-pin, three-port pin map.
*/
package pxc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPIN  = 21;
  localparam int NSLOT = 17;
  localparam int NPORT = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ROUTE_LO   = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_HI   = 8'hE2;
  localparam logic [7:0] ADDR_SKIP_BASE  = 8'hD4;
  localparam logic [7:0] ADDR_MDIN_BASE  = 8'hF1;
  localparam logic [7:0] ADDR_MDOUT_BASE = 8'hA4;
  localparam logic [7:0] ADDR_PORT_BASE  = 8'hB4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LO_UART  = 0;
  localparam int LO_SPI   = 1;
  localparam int LO_SMB   = 2;
  localparam int LO_SYSCK = 3;
  localparam int LO_CMP   = 4;
  localparam int LO_CMPA  = 5;
  localparam int HI_CMOD  = 0;
  localparam int HI_ECI   = 3;
  localparam int HI_T0    = 4;
  localparam int HI_T1    = 5;
  localparam int HI_XBAR  = 6;
  localparam int HI_WPUD  = 7;

  localparam logic [7:0] ROUTE_LO_MASK = 8'h3F;
  localparam logic [7:0] ROUTE_HI_MASK = 8'hFB;
  localparam logic [7:0] PORT2_MASK    = 8'h1F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] SKIP_RST  = 8'h00;
  localparam logic [7:0] MDIN_RST  = 8'hFF;
  localparam logic [7:0] MDOUT_RST = 8'h00;
  localparam logic [7:0] PORT_RST  = 8'hFF;

  // ----------------------------------------------------------------
  // Slots in priority order and fixed pins
  // ----------------------------------------------------------------
  localparam logic [4:0] SL_UTX  = 5'h00;
  localparam logic [4:0] SL_URX  = 5'h01;
  localparam logic [4:0] SL_SDA  = 5'h06;
  localparam logic [4:0] SL_SCL  = 5'h07;
  localparam int         SL_NSS  = 5;
  localparam int         SL_COUNTER_MODULE0_PIN = 11;
  localparam int         UART_TX_PIN = 4;
  localparam int         UART_RX_PIN = 5;
  localparam int         P20_PIN     = 16;

endpackage

/* tb/pxc_pin_monitor.sv */
/*
  Port-level checks of the crossbar, bound to its top module.
  Assumes the route and input-mode registers change only by writes.
*/
`timescale 1ns/10ps
`default_nettype none
module pxc_pin_monitor
  import pxc_pkg::*;
#(
  parameter int LARGE_PKG = 1
)
(
  input wire logic             CLK_IN,
  input wire logic             SRST_IN,
  input wire logic [7:0]       ADDR_IN,
  input wire logic [7:0]       WDATA_IN,
  input wire logic             WR_IN,
  input wire logic             RD_IN,
  input wire logic [7:0]       RDATA_OUT,
  input wire logic             SPI_FOUR_WIRE_IN,
  input wire logic [NSLOT-1:0] PERIPH_O_IN,
  input wire logic [NSLOT-1:0] PERIPH_OE_IN,
  input wire logic [NSLOT-1:0] PERIPH_I_OUT,
  input wire logic [NPIN-1:0]  PIN_O_OUT,
  input wire logic [NPIN-1:0]  PIN_OE_OUT,
  input wire logic [NPIN-1:0]  PIN_PU_OUT
);
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [7:0] din_q;

  // Shadows of the registers that the checks depend on.
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      lo_q  <= ROUTE_RST;
      hi_q  <= ROUTE_RST;
      din_q <= MDIN_RST;
    end
    else if (WR_IN)
    begin
      if (ADDR_IN == ADDR_ROUTE_LO)
        lo_q <= WDATA_IN;
      if (ADDR_IN == ADDR_ROUTE_HI)
        hi_q <= WDATA_IN;
      if (ADDR_IN == ADDR_MDIN_BASE)
        din_q <= WDATA_IN;
    end
  end

  default clocking mon_cb @(posedge CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  sequence s_uart_drive;
    hi_q[HI_XBAR] && lo_q[LO_UART] && din_q[UART_TX_PIN]
      && PERIPH_OE_IN[0] && !PERIPH_O_IN[0];
  endsequence

  sequence s_quiet;
    !WR_IN && $stable(PERIPH_OE_IN) && $stable(PERIPH_O_IN)
      && $stable(SPI_FOUR_WIRE_IN);
  endsequence

  uart_tx_pin_a: assert property (s_uart_drive |=> PIN_OE_OUT[UART_TX_PIN])
    else $error("uart transmit pin not driven");
  rdata_idle_a: assert property (RDATA_OUT != 8'h00 |-> $past(RD_IN))
    else $error("read data without a read");
  lo_read_a: assert property (RD_IN && ADDR_IN == ADDR_ROUTE_LO
    |=> RDATA_OUT == (lo_q & ROUTE_LO_MASK)) else $error("low route readback wrong");
  hi_read_a: assert property (RD_IN && ADDR_IN == ADDR_ROUTE_HI
    |=> RDATA_OUT == (hi_q & ROUTE_HI_MASK)) else $error("high route readback wrong");
  xbar_off_a: assert property (!hi_q[HI_XBAR]
    |=> PIN_OE_OUT == '0 && &PERIPH_I_OUT) else $error("pins active with crossbar off");
  analog_pin_a: assert property (din_q != 8'hFF
    |=> ((PIN_OE_OUT[7:0] | PIN_PU_OUT[7:0]) & ~$past(din_q)) == 8'h00)
    else $error("analog pin driven or pulled");
  pull_drive_a: assert property ((PIN_OE_OUT & ~PIN_O_OUT & PIN_PU_OUT) == '0)
    else $error("pullup on while driving zero");
  pull_disable_a: assert property (hi_q[HI_WPUD] |=> PIN_PU_OUT == '0)
    else $error("pullup on while disabled");
  steady_route_a: assert property (s_quiet [*3] |-> $stable(PIN_OE_OUT))
    else $error("drive changed without cause");
endmodule
`default_nettype wire

/* tb/pxc_board.sv */
/*
  Board and pad model: resolves each pin level from the crossbar drive,
  the weak pullup and a floating level. Assumes one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pxc_board
(
  input  wire logic        clk_in,
  input  wire logic [20:0] pin_o_in,
  input  wire logic [20:0] pin_oe_in,
  input  wire logic [20:0] pin_pu_in,
  output logic      [20:0] pin_lvl_out
);
  logic [20:0] float_q = 21'h0AAAAA;

  // A floating pad toggles every cycle so no stale level is read.
  always_ff @(posedge clk_in)
    float_q <= ~float_q;

  assign pin_lvl_out = (pin_oe_in & pin_o_in) | (~pin_oe_in & (pin_pu_in | float_q));
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench of the crossbar: register port, routing, pad modes.
  Assumes the board model answers the pads and the bench plays peripherals.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pxc_pkg::*;
  localparam int LARGE_PKG = 1;
  logic clk, srst, wr, rd, four;
  logic [7:0] addr, wdata, rdata, d;
  logic [NSLOT-1:0] po, poe, pi;
  logic [NPIN-1:0] pin_i, pin_o, pin_oe, pin_pu;
  int failures = 0;
  int tests_run = 0;
  logic [23:0] rows [5] = '{24'hE1FF3F, 24'hE20400, 24'hD6FF1F, 24'h55AA00, 24'hF1F0F0};
  logic [15:0] rst_rows [4] = '{16'hE100, 16'hE200, 16'hF1FF, 16'hA400};
  logic [15:0] cnt_rows [6] = '{16'h4000, 16'h4101, 16'h4203, 16'h4307, 16'h7807, 16'h7B3F};

  pxc_crossbar #(.LARGE_PKG(LARGE_PKG)) pxc_crossbar_inst (
    .CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SPI_FOUR_WIRE_IN(four),
    .PERIPH_O_IN(po), .PERIPH_OE_IN(poe), .PERIPH_I_OUT(pi), .PIN_I_IN(pin_i),
    .PIN_O_OUT(pin_o), .PIN_OE_OUT(pin_oe), .PIN_PU_OUT(pin_pu));
  pxc_board pxc_board_inst (.clk_in(clk), .pin_o_in(pin_o), .pin_oe_in(pin_oe),
    .pin_pu_in(pin_pu), .pin_lvl_out(pin_i));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    four = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    po = '0;
    poe = '1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (rows[i])
    begin
      wr_reg(rows[i][23:16], rows[i][15:8]);
      rd_reg(rows[i][23:16], d);
      check("readback", d, rows[i][7:0]);
    end
    $display("register rows done");
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    foreach (rst_rows[i])
    begin
      rd_reg(rst_rows[i][15:8], d);
      check("reset value", d, rst_rows[i][7:0]);
    end
    wr_reg(ADDR_ROUTE_LO, 8'h01);
    settle();
    check("drive off", pin_oe, 21'h0);
    check("pullup idle", pin_pu, 21'h1FFFFF);
    $display("reset and disabled crossbar done");
    wr_reg(ADDR_SKIP_BASE, 8'h0C);
    wr_reg(ADDR_ROUTE_LO, 8'h05);
    wr_reg(ADDR_ROUTE_HI, 8'h41);
    settle();
    check("priority drive", pin_oe, 21'h000073);
    check("priority pullup", pin_pu, 21'h1FFF8C);
    check("data return", pi[6], 1'b0);
    check("unrouted return", pi[2], 1'b1);
    $display("priority example done");
    wr_reg(ADDR_SKIP_BASE, 8'h00);
    wr_reg(ADDR_ROUTE_LO, 8'h12);
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk);
      four <= f[0];
      settle();
      check("serial pins", pin_oe, f ? 21'h3F : 21'h1F);
    end
    wr_reg(ADDR_ROUTE_LO, 8'h00);
    foreach (cnt_rows[i])
    begin
      wr_reg(ADDR_ROUTE_HI, cnt_rows[i][15:8]);
      settle();
      check("counter pins", pin_oe, {13'h0, cnt_rows[i][7:0]});
    end
    $display("serial and counter routing done");
    wr_reg(ADDR_MDOUT_BASE, 8'hFF);
    wr_reg(ADDR_ROUTE_LO, 8'h04);
    wr_reg(ADDR_ROUTE_HI, 8'h40);
    @(posedge clk);
    po <= '1;
    settle();
    check("open drain", pin_oe, 21'h0000FC);
    check("data pullup", pin_pu[0], 1'b1);
    check("pad value", pin_o, 21'h0000FC);
    wr_reg(ADDR_MDIN_BASE, 8'hFE);
    settle();
    check("analog pullup", pin_pu[0], 1'b0);
    rd_reg(ADDR_PORT_BASE, d);
    check("port read", d, 8'hFE);
    wr_reg(ADDR_PORT_BASE, 8'h7F);
    settle();
    check("port latch", pin_o[7:0], 8'h7C);
    wr_reg(ADDR_ROUTE_HI, 8'hC0);
    settle();
    check("pullup disable", pin_pu, 21'h0);
    $display("pad mode tests done");
    final_report();
  end
endmodule

bind pxc_crossbar pxc_pin_monitor #(.LARGE_PKG(LARGE_PKG)) pxc_pin_monitor_inst (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .SPI_FOUR_WIRE_IN(SPI_FOUR_WIRE_IN), .PERIPH_O_IN(PERIPH_O_IN),
  .PERIPH_OE_IN(PERIPH_OE_IN), .PERIPH_I_OUT(PERIPH_I_OUT), .PIN_O_OUT(PIN_O_OUT),
  .PIN_OE_OUT(PIN_OE_OUT), .PIN_PU_OUT(PIN_PU_OUT));
`default_nettype wire
